// [core/sef_pkg.sv]
/*
 * Constants shared by the serial error and busy flag logic.
 * Assumes a single 50 MHz core clock and a byte-wide serial link.
 */
package sef_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************

  // Core clock period in nanoseconds.
  localparam int CORE_CLK_PERIOD_NS = 20;
  // Delay from a data write to the busy flag, in core clock periods.
  localparam int BUSY_DELAY_CYCLES = 2;

  // ****************************************************************
  // Frame layout and reset values
  // ****************************************************************

  // Bits in one serial frame.
  localparam int FRAME_BITS = 8;
  // Width of the bit counter within a frame.
  localparam int BIT_COUNT_WIDTH = 3;
  // Last bit index of a frame.
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
  // Reset value of every data and shift register.
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Reset value of the transmit empty flag.
  localparam logic TX_EMPTY_RESET = 1'b1;

endpackage : sef_pkg

// [core/sef_error_flags.sv]
/*
 * Error detection and busy flag timing for a synchronous serial port.
 * Assumes software access strobes are one-cycle pulses on core_clk and
 * that the serial clock, data and select pins are asynchronous.
 */
//
// Contract
// - The busy flag rises two core clock periods after a data write, never in the same cycle.
// - As master, a low select pin (hardware mode) or low internal select bit sets mode fault.
// - A mode fault sets its flag and raises the error request when error interrupts are enabled.
// - A mode fault clears the peripheral enable, which drops serial_out_en; serial_out itself is not gated.
// - A mode fault clears the master select bit so the port falls back to slave.
// - Mode fault clears only on a status access while set followed by a control one write.
// - Writes that try to set enable or master select are ignored while mode fault is set.
// - A slave never sets mode fault, and a flag left set after the fall to slave persists.
// - Overrun is detected when a byte completes while receive not empty is still set.
// - Overrun sets its flag and raises the error request when error interrupts are enabled.
// - During overrun the old byte stays readable and the new and later bytes are dropped.
// - Overrun clears only when a data read is followed by a status read.
// - With checking enabled, a received check byte differing from the receive check sets error.
`timescale 1ns/1ns

module sef_error_flags
  import sef_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial link pins.
  input wire logic link_clk_pin,
  input wire logic serial_in_pin,
  input wire logic slave_select_pin,
  output logic serial_out,
  output logic serial_out_en,
  // Control register one writes.
  input wire logic control_register_one_write,
  input wire logic wr_peripheral_enable_bit,
  input wire logic wr_master_select_bit,
  // Static configuration bits.
  input wire logic soft_select_mode,
  input wire logic internal_select_bit,
  input wire logic crc_enable_bit,
  input wire logic error_irq_enable,
  input wire logic crc_next_frame,
  input wire logic [7:0] rx_check_register,
  // Data and status register accesses.
  input wire logic data_register_write,
  input wire logic [7:0] data_write_value,
  input wire logic data_register_read,
  input wire logic status_register_read,
  input wire logic status_register_write,
  input wire logic crc_flag_clear,
  // Control and status outputs.
  output logic peripheral_enable_bit,
  output logic master_select_bit,
  output logic [7:0] data_read_value,
  output logic rx_not_empty_flag,
  output logic tx_empty_flag,
  output logic busy_flag,
  output logic mode_fault_flag,
  output logic overrun_flag,
  output logic crc_mismatch_flag,
  output logic error_irq
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [1:0] sclk_sync_reg;
  logic sclk_prev_reg;
  logic [1:0] sin_sync_reg;
  logic [1:0] nss_sync_reg;
  logic sclk_rise;
  logic sclk_fall;

  // Two flops per pin; only the second stage feeds any logic.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
      sin_sync_reg <= 2'h0;
      nss_sync_reg <= 2'h3;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], link_clk_pin};
      sclk_prev_reg <= sclk_sync_reg[1];
      sin_sync_reg <= {sin_sync_reg[0], serial_in_pin};
      nss_sync_reg <= {nss_sync_reg[0], slave_select_pin};
    end
  end

  // Edge detection looks only at the second stage and its delayed copy.
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;

  // ****************************************************************
  // Mode fault and control bits
  // ****************************************************************

  logic enable_reg;
  logic master_reg;
  logic mode_fault_flag_reg;
  logic mode_fault_flag_armed_reg;
  logic select_low;
  logic mode_fault_flag_event;

  // Selection comes from the internal bit in soft mode, else the pin.
  assign select_low = soft_select_mode ? ~internal_select_bit : ~nss_sync_reg[1];
  assign mode_fault_flag_event = master_reg & select_low;

  // A fault drops enable and master; sets are refused while the flag is set.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (mode_fault_flag_event) begin
      enable_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (control_register_one_write) begin
      enable_reg <= wr_peripheral_enable_bit & ~mode_fault_flag_reg;
      master_reg <= wr_master_select_bit & ~mode_fault_flag_reg;
    end
  end

  // Clearing takes a status access first, then a control one write.
  // A new fault in the clearing cycle wins so the event is not lost.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_armed_reg <= 1'b0;
    end else if (mode_fault_flag_event) begin
      mode_fault_flag_reg <= 1'b1;
      mode_fault_flag_armed_reg <= 1'b0;
    end else if (mode_fault_flag_reg && mode_fault_flag_armed_reg && control_register_one_write) begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_armed_reg <= 1'b0;
    end else if (mode_fault_flag_reg && (status_register_read || status_register_write)) begin
      mode_fault_flag_armed_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Shifting and reception
  // ****************************************************************

  logic [7:0] rx_shift_reg;
  logic [BIT_COUNT_WIDTH-1:0] bit_count_reg;
  logic [7:0] tx_shift_reg;
  logic byte_done;
  logic [7:0] rx_byte;

  // Bits are sampled on rising link clock edges while enabled.
  assign byte_done = enable_reg & sclk_rise & (bit_count_reg == LAST_BIT_INDEX);
  assign rx_byte = {rx_shift_reg[6:0], sin_sync_reg[1]};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_reg <= DATA_RESET;
      bit_count_reg <= '0;
    end else if (!enable_reg) begin
      bit_count_reg <= '0;
    end else if (sclk_rise) begin
      rx_shift_reg <= rx_byte;
      bit_count_reg <= bit_count_reg + 3'h1;
    end
  end

  // ****************************************************************
  // Transmit path and busy timing
  // ****************************************************************

  logic [BUSY_DELAY_CYCLES-1:0] write_delay_reg;
  logic load_now;

  // The write is carried through a two-stage pipe before busy rises.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_delay_reg <= '0;
    end else begin
      write_delay_reg <= {write_delay_reg[BUSY_DELAY_CYCLES-2:0], data_register_write};
    end
  end
  assign load_now = write_delay_reg[BUSY_DELAY_CYCLES-1];

  // Busy stays up until a frame ends with nothing left to send or the port is disabled.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_flag <= 1'b0;
    end else if (load_now) begin
      busy_flag <= 1'b1;
    end else if (!enable_reg || (byte_done && tx_empty_flag)) begin
      busy_flag <= 1'b0;
    end
  end

  // Transmit empty drops on a write and rises when the shifter takes it.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_empty_flag <= TX_EMPTY_RESET;
    end else if (data_register_write) begin
      tx_empty_flag <= 1'b0;
    end else if (load_now) begin
      tx_empty_flag <= 1'b1;
    end
  end

  logic [7:0] tx_hold_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold_reg <= DATA_RESET;
      tx_shift_reg <= DATA_RESET;
    end else begin
      if (data_register_write) begin
        tx_hold_reg <= data_write_value;
      end
      if (load_now) begin
        tx_shift_reg <= tx_hold_reg;
      end else if (enable_reg && sclk_fall) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // Disabling drops only serial_out_en; serial_out still shows the shifter's top bit.
  assign serial_out = tx_shift_reg[7];
  assign serial_out_en = enable_reg;

  // ****************************************************************
  // Receive buffer and overrun
  // ****************************************************************

  logic ovr_armed_reg;
  logic overrun_event;

  assign overrun_event = byte_done & rx_not_empty_flag;

  // During overrun nothing new reaches the buffer.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_read_value <= DATA_RESET;
    end else if (byte_done && !rx_not_empty_flag && !overrun_flag) begin
      data_read_value <= rx_byte;
    end
  end

  // A completed byte sets receive not empty ahead of a same-cycle read.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_not_empty_flag <= 1'b0;
    end else if (byte_done && !overrun_flag && !rx_not_empty_flag) begin
      rx_not_empty_flag <= 1'b1;
    end else if (data_register_read) begin
      rx_not_empty_flag <= 1'b0;
    end
  end

  // Overrun clears on a data read then a status read; a new one wins.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun_flag <= 1'b0;
      ovr_armed_reg <= 1'b0;
    end else if (overrun_event) begin
      overrun_flag <= 1'b1;
      ovr_armed_reg <= 1'b0;
    end else if (overrun_flag && ovr_armed_reg && status_register_read) begin
      overrun_flag <= 1'b0;
      ovr_armed_reg <= 1'b0;
    end else if (overrun_flag && data_register_read) begin
      ovr_armed_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Check byte compare and error request
  // ****************************************************************

  // The byte completing while crc_next_frame is set is compared with the receive value.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_mismatch_flag <= 1'b0;
    end else if (crc_enable_bit && crc_next_frame && byte_done
                 && (rx_byte != rx_check_register)) begin
      crc_mismatch_flag <= 1'b1;
    end else if (crc_flag_clear) begin
      crc_mismatch_flag <= 1'b0;
    end
  end

  assign error_irq = error_irq_enable
                     & (mode_fault_flag_reg | overrun_flag | crc_mismatch_flag);
  assign peripheral_enable_bit = enable_reg;
  assign master_select_bit = master_reg;
  assign mode_fault_flag = mode_fault_flag_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Busy is written two edges after the write edge, so it is first sampled high one edge later.
  AST_BUSY_DELAY: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    data_register_write |=> ##2 busy_flag)
    else $error("Busy did not rise two cycles after a data write.");

  AST_BUSY_NOT_EARLY: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (data_register_write && !busy_flag && !load_now && !write_delay_reg[0])
      |=> !busy_flag ##1 !busy_flag)
    else $error("Busy rose too early after a data write.");

  AST_MODE_FAULT_FLAG_SET: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (master_select_bit && select_low) |=> mode_fault_flag && !master_select_bit
                                          && !peripheral_enable_bit)
    else $error("Mode fault did not set and drop the port.");

  AST_OUT_RELEASED: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(mode_fault_flag) |-> !serial_out_en)
    else $error("Link output still enabled after a mode fault.");

  AST_NO_SET_UNDER_MODE_FAULT_FLAG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_fault_flag && !peripheral_enable_bit && !master_select_bit)
      |=> !peripheral_enable_bit && !master_select_bit)
    else $error("Enable was set while mode fault was set.");

  AST_SLAVE_NO_MODE_FAULT_FLAG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!master_select_bit && !mode_fault_flag) |=> !mode_fault_flag)
    else $error("A slave set mode fault.");

  AST_MODE_FAULT_FLAG_CLEAR_ORDER: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(mode_fault_flag) |-> $past(control_register_one_write) && $past(mode_fault_flag_armed_reg))
    else $error("Mode fault cleared without the access sequence.");

  AST_OVR_SET: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (byte_done && rx_not_empty_flag) |=> overrun_flag)
    else $error("Overrun not flagged.");

  AST_OVR_KEEPS_DATA: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    overrun_flag |=> $stable(data_read_value))
    else $error("Receive buffer changed during overrun.");

  AST_OVR_CLEAR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(overrun_flag) |-> $past(status_register_read) && $past(ovr_armed_reg))
    else $error("Overrun cleared out of order.");

  AST_CRC_SET: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (crc_enable_bit && crc_next_frame && byte_done && rx_byte != rx_check_register)
      |=> crc_mismatch_flag)
    else $error("Check byte mismatch not flagged.");

  AST_IRQ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    error_irq == (error_irq_enable && (mode_fault_flag || overrun_flag || crc_mismatch_flag)))
    else $error("Error request does not follow flags.");

endmodule : sef_error_flags

// [sim/sef_link_master.sv]
/*
 * Behavioural serial link master facing the error flag block.
 * Assumes the bench pulses go with a byte ready and watches done.
 */
`timescale 1ns/1ns

module sef_link_master (
  // Bench control.
  input wire logic go,
  input wire logic [7:0] tx_byte,
  input wire logic sel_low,
  output logic done,
  output logic [7:0] seen_byte,
  // Link pins.
  input wire logic serial_out,
  output logic link_clk_pin,
  output logic serial_in_pin,
  output logic slave_select_pin
);
  // ****************************************************************
  // Frame generation
  // ****************************************************************

  // The select line stays high unless the bench pulls it low.
  assign slave_select_pin = !sel_low;

  // Clock idles low between frames; data changes while the clock is low.
  initial begin
    link_clk_pin = 1'b0;
    serial_in_pin = 1'b0;
    done = 1'b1;
  end

  // Eight bits MSB first at 160 ns; the released data line shows the inverse.
  always @(posedge go) begin
    done = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_in_pin = tx_byte[i];
      #80 link_clk_pin = 1'b1;
      #80 link_clk_pin = 1'b0;
    end
    serial_in_pin = ~tx_byte[0];
    done = 1'b1;
  end

  // The block's outgoing bits are taken on the rising link clock edge, MSB first.
  always @(posedge link_clk_pin) begin
    seen_byte <= {seen_byte[6:0], serial_out};
  end
endmodule : sef_link_master

// [sim/tb_top.sv]
/*
 * Self-checking bench for the serial error and busy flag block.
 * Assumes the link master model and one 50 MHz core clock.
 */
`timescale 1ns/1ns

module tb_top
  import sef_pkg::*;
;
  typedef struct {int sel; logic [7:0] exp;} sef_note_t;
  logic core_clk, reset_n, go, sel_low, done, link_clk_pin, serial_in_pin, slave_select_pin;
  logic serial_out, serial_out_en, ctl_wr, wr_en, wr_ms, soft_mode, int_sel, crc_en, irq_en;
  logic crc_next, dwr, drd, srd, swr, crc_clr, peripheral_enable_bit, master_select_bit;
  logic rx_not_empty_flag, tx_empty_flag, busy_flag, mode_fault_flag, overrun_flag;
  logic crc_mismatch_flag, error_irq;
  logic [7:0] rx_chk, wr_val, tx_byte, data_read_value, b, seen_byte;
  int failures, comparisons, cycles;
  sef_note_t notes[$];
  sef_note_t n;
  string nm[12] = '{"data", "busy", "txe", "rx_not_empty_flag", "mode_fault_flag", "ovr", "crc", "irq", "en", "ms", "oe",
    "sout"};

  // ****************************************************************
  // Design, link model and clock
  // ****************************************************************

  sef_error_flags i_sef_error_flags (.core_clk(core_clk), .reset_n(reset_n),
    .link_clk_pin(link_clk_pin), .serial_in_pin(serial_in_pin),
    .slave_select_pin(slave_select_pin), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .control_register_one_write(ctl_wr),
    .wr_peripheral_enable_bit(wr_en), .wr_master_select_bit(wr_ms),
    .soft_select_mode(soft_mode), .internal_select_bit(int_sel), .crc_enable_bit(crc_en),
    .error_irq_enable(irq_en), .crc_next_frame(crc_next), .rx_check_register(rx_chk),
    .data_register_write(dwr), .data_write_value(wr_val), .data_register_read(drd),
    .status_register_read(srd), .status_register_write(swr), .crc_flag_clear(crc_clr),
    .peripheral_enable_bit(peripheral_enable_bit), .master_select_bit(master_select_bit),
    .data_read_value(data_read_value), .rx_not_empty_flag(rx_not_empty_flag),
    .tx_empty_flag(tx_empty_flag), .busy_flag(busy_flag), .mode_fault_flag(mode_fault_flag),
    .overrun_flag(overrun_flag), .crc_mismatch_flag(crc_mismatch_flag), .error_irq(error_irq));

  sef_link_master i_sef_link_master (.go(go), .tx_byte(tx_byte), .sel_low(sel_low),
    .done(done), .seen_byte(seen_byte), .serial_out(serial_out),
    .link_clk_pin(link_clk_pin), .serial_in_pin(serial_in_pin),
    .slave_select_pin(slave_select_pin));

  // Free running core clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Checking
  // ****************************************************************

  function automatic logic [7:0] obs(input int s);
    logic [10:0] f;
    f = {serial_out_en, master_select_bit, peripheral_enable_bit, error_irq, crc_mismatch_flag,
      overrun_flag, mode_fault_flag, rx_not_empty_flag, tx_empty_flag, busy_flag, 1'b0};
    return (s == 0) ? data_read_value : (s == 11) ? seen_byte : {7'h00, f[s]};
  endfunction : obs

  // Notes are compared at the next rising edge, on values settled since the falling edge.
  always @(posedge core_clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      comparisons++;
      if (obs(n.sel) !== n.exp) begin
        failures++;
        $display("BAD %s expected %h seen %h", nm[n.sel], n.exp, obs(n.sel));
      end
    end
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // Drivers, all entered and left at a falling edge
  // ****************************************************************

  task automatic ck(input int s, input logic [7:0] e);
    notes.push_back('{s, e});
  endtask : ck

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  task automatic ctl(input logic e, input logic m);
    wr_en = e;
    wr_ms = m;
    pulse(ctl_wr);
  endtask : ctl

  // Bounded wait on an output; six cycles after done let the synchronisers settle.
  task automatic send(input logic [7:0] v);
    tx_byte = v;
    pulse(go);
    repeat (200) if (done !== 1'b1) cyc(1);
    cyc(6);
  endtask : send

  task automatic wait_for(input int s, input logic [7:0] e);
    repeat (400) if (obs(s) !== e) cyc(1);
    ck(s, e);
    cyc(1);
  endtask : wait_for

  // ****************************************************************
  // Main sequence
  // ****************************************************************

  initial begin
    {reset_n, go, sel_low, ctl_wr, wr_en, wr_ms, soft_mode, crc_en, irq_en} = '0;
    {crc_next, dwr, drd, srd, swr, crc_clr, rx_chk, wr_val, tx_byte} = '0;
    int_sel = 1'b1;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'hA73A));
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    ck(2, 8'h01);
    ck(1, 8'h00);
    cyc(1);
    // Busy rises only after the fixed delay, then drains after the byte.
    soft_mode = 1'b1;
    irq_en = 1'b1;
    ctl(1'b1, 1'b1);
    ck(8, 8'h01);
    ck(9, 8'h01);
    wr_val = 8'($urandom);
    pulse(dwr);
    for (int i = 0; i < BUSY_DELAY_CYCLES; i++) begin
      ck(1, 8'h00);
      cyc(1);
    end
    ck(1, 8'h01);
    b = 8'($urandom);
    send(b);
    ck(11, wr_val);
    wait_for(2, 8'h01);
    wait_for(1, 8'h00);
    ck(3, 8'h01);
    $display("test busy done");
    // Two more bytes arrive while the first is unread.
    send(~b);
    ck(5, 8'h01);
    ck(7, 8'h01);
    send(8'($urandom));
    ck(0, b);
    irq_en = 1'b0;
    ck(7, 8'h00);
    cyc(1);
    irq_en = 1'b1;
    pulse(srd);
    ck(5, 8'h01);
    pulse(drd);
    pulse(srd);
    ck(5, 8'h00);
    ck(7, 8'h00);
    cyc(1);
    $display("test overrun done");
    // Hardware select fault while master.
    soft_mode = 1'b0;
    sel_low = 1'b1;
    wait_for(4, 8'h01);
    ck(8, 8'h00);
    ck(10, 8'h00);
    ck(9, 8'h00);
    ck(7, 8'h01);
    sel_low = 1'b0;
    cyc(4);
    ctl(1'b1, 1'b1);
    ck(8, 8'h00);
    ck(9, 8'h00);
    ck(4, 8'h01);
    pulse(srd);
    ctl(1'b1, 1'b1);
    ck(4, 8'h00);
    cyc(1);
    ctl(1'b1, 1'b1);
    ck(8, 8'h01);
    ck(9, 8'h01);
    cyc(1);
    // An enabled slave never faults.
    ctl(1'b1, 1'b0);
    sel_low = 1'b1;
    cyc(8);
    ck(4, 8'h00);
    sel_low = 1'b0;
    // Software select fault, cleared through a status write.
    soft_mode = 1'b1;
    ctl(1'b1, 1'b1);
    int_sel = 1'b0;
    wait_for(4, 8'h01);
    cyc(8);
    ck(4, 8'h01);
    pulse(swr);
    ctl(1'b0, 1'b0);
    ck(4, 8'h00);
    cyc(1);
    $display("test mode fault done");
    // Check byte mismatch and match, as a selected slave.
    ctl(1'b1, 1'b0);
    crc_en = 1'b1;
    crc_next = 1'b1;
    rx_chk = 8'($urandom);
    send(rx_chk ^ 8'h5A);
    ck(6, 8'h01);
    ck(7, 8'h01);
    pulse(crc_clr);
    pulse(drd);
    ck(6, 8'h00);
    send(rx_chk);
    ck(6, 8'h00);
    cyc(1);
    $display("test check byte done");
    cyc(2);
    conclude();
  end
endmodule : tb_top
